// ### core/touch_i2c_pkg.sv
package touch_i2c_pkg;

    // Target address pairs, write and read byte values
    localparam logic [7:0] PAIR_A_WR = 8'hba;
    localparam logic [7:0] PAIR_A_RD = 8'hbb;
    localparam logic [7:0] PAIR_B_WR = 8'h28;
    localparam logic [7:0] PAIR_B_RD = 8'h29;

    // Bit positions within a nine-clock byte frame
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_LAST  = 4'h7;
    localparam logic [3:0] BIT_ACK   = 4'h8;
    localparam logic [3:0] BIT_NEW   = 4'h2;   // Bits seen when a start shows

    // Positions in the target's vector of pin and toggle synchronisers
    localparam int SYN_SCL = 0;
    localparam int SYN_SDA = 1;
    localparam int SYN_RST = 2;
    localparam int SYN_INT = 3;
    localparam int SYN_WR  = 4;
    localparam int SYN_PTR = 5;
    localparam int SYN_W   = 6;

    // Reset values
    localparam logic [15:0] PTR_RST  = 16'h0000;
    localparam logic        PAIR_RST = 1'b0;

    // Link rate and strap timing, in ns and kbit/s, and derived cycles
    localparam int REF_PERIOD_NS  = 10;
    localparam int BUS_RATE_KBPS  = 400;
    localparam int BIT_TIME_NS    = 1000000 / BUS_RATE_KBPS;
    // Quarter bit rounds up so the rate never exceeds the limit
    localparam int QUARTER_CYC    = (BIT_TIME_NS + 4 * REF_PERIOD_NS - 1)
                                    / (4 * REF_PERIOD_NS);
    localparam int STRAP_RST_NS   = 10000;
    localparam int STRAP_INT_NS   = 5000;
    localparam int STRAP_RST_CYC  = (STRAP_RST_NS + REF_PERIOD_NS - 1)
                                    / REF_PERIOD_NS;
    localparam int STRAP_END_CYC  = STRAP_RST_CYC
                                    + (STRAP_INT_NS + REF_PERIOD_NS - 1)
                                    / REF_PERIOD_NS;

    // Target byte-level phases
    typedef enum logic [5:0] {
        PH_IDLE  = 6'h01,
        PH_ADDR  = 6'h02,
        PH_PTRH  = 6'h04,
        PH_PTRL  = 6'h08,
        PH_WDATA = 6'h10,
        PH_RDATA = 6'h20
    } link_phase_t;

    // Host sequencer states
    typedef enum logic [5:0] {
        HS_STRAP = 6'h01,
        HS_IDLE  = 6'h02,
        HS_START = 6'h04,
        HS_TX    = 6'h08,
        HS_RX    = 6'h10,
        HS_STOP  = 6'h20
    } host_state_t;

endpackage : touch_i2c_pkg

// ### core/touch_i2c_if.sv
`timescale 1ns/100ps
interface touch_i2c_if;
    // Link clock, made by the host
    logic scl;
    // Open-drain data line, one driver set per end
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;
    // Strap pins, driven by the host during power-on
    logic dev_rst_n;
    logic int_host_o;
    logic int_host_oe_n;
    // Resolved wires; released data floats high on the pull-up, released int reads low
    logic sda;
    logic int_pin;

    // Wired-and of both data drivers
    assign sda     = (sda_host_oe_n | sda_host_o)
                   & (sda_dev_oe_n | sda_dev_o);
    assign int_pin = ~int_host_oe_n & int_host_o;

    modport host (
        output scl, sda_host_o, sda_host_oe_n,
        output dev_rst_n, int_host_o, int_host_oe_n,
        input  sda
    );
    modport target (
        input  scl, sda, dev_rst_n, int_pin,
        output sda_dev_o, sda_dev_oe_n
    );
endinterface : touch_i2c_if

// ### core/touch_i2c_target.sv
`timescale 1ns/100ps
// Operation
// (RQ1) Answer only the selected address pair
// (RQ2) Latch pair choice from strap pins
// (RQ3) Host starts every transaction, target only
// (RQ4) Matching address: drive ack low, ninth clock
// (RQ5) Mismatch: no ack, idle until start
// (RQ6) Nine clocks per byte, receiver acks
// (RQ7) Sample while clock high, change while low
// (RQ8) Write: address, 16-bit pointer, data bytes
// (RQ9) Pointer advances after each written byte
// (RQ10) Stop ends multi-byte write
// (RQ11) Read first loads pointer by write
// (RQ12) Repeated start, read address, send bytes
// (RQ13) Keep sending while host acknowledges
// (RQ14) Host nack and stop end read
// (RQ15) Host keeps rate at 400 kbit/s
// (RQ16) Pointer advances after each sent byte; the code advances it only on a host ack, not after the nacked last byte
module touch_i2c_target
    import touch_i2c_pkg::*;
(
    // System clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Link pins
    touch_i2c_if.target      bus,
    // Register space write port
    output logic             reg_wr,
    output logic [15:0]      reg_wr_addr,
    output logic [7:0]       reg_wr_data,
    // Register space read port
    output logic [15:0]      reg_rd_addr,
    input  wire logic [7:0]  reg_rd_data,
    // Status
    output logic             xfer_done,
    output logic             pair_sel
);

    // ---------------- System clock domain ----------------
    logic [SYN_W-1:0] syn1_reg, syn2_reg, syn3_reg, filt_reg;
    logic [SYN_W-1:0] pins_async, filt_next;
    logic             frame_tgl_reg, link_en_reg;
    logic             reg_wr_reg, xfer_done_reg, pair_sel_reg;
    logic [15:0]      reg_wr_addr_reg, reg_rd_addr_reg;
    logic [7:0]       reg_wr_data_reg, rd_byte_reg;
    logic             start_seen, stop_seen, strap_rise;
    logic             wr_event, ptr_event;

    // ---------------- Link clock domain ------------------
    logic             lrst1_reg, lrst2_reg, fr1_reg, fr2_reg, seen_reg;
    logic             ps1_reg, ps2_reg;
    logic [7:0]       sh_reg, byte_in, tx_reg, tx_next, own_wr, own_rd;
    logic [3:0]       cnt_reg, cnt_next;
    link_phase_t      phase_reg, phase_next;
    logic             ack_go_reg, ack_go_next;
    logic [15:0]      ptr_reg, wr_addr_hold;
    logic [7:0]       wr_data_hold;
    logic             ptr_tgl_reg, wr_tgl_reg;
    logic             sda_oe_n_reg, sda_o_reg, oe_n_next;
    logic             new_frame, byte_done, ack_slot, host_ack, host_nack;
    logic             hit_wr, hit_rd, hit_any, drive_bit;

    // Pins and link toggles enter through three flops; a change counts
    // once the second and third agree
    assign pins_async = {ptr_tgl_reg, wr_tgl_reg, bus.int_pin,
                         bus.dev_rst_n, bus.sda, bus.scl};
    assign filt_next  = (syn2_reg & syn3_reg)
                      | (filt_reg & (syn2_reg | syn3_reg));

    always_ff @(posedge ref_clk) begin
        syn1_reg <= pins_async;
        syn2_reg <= syn1_reg;
        syn3_reg <= syn2_reg;
        filt_reg <= rst_n ? filt_next : '1;
    end

    // Start and stop are data edges while the clock stays high
    // (RQ7) start stop detection
    assign start_seen = filt_reg[SYN_SCL] & filt_next[SYN_SCL]
                      & filt_reg[SYN_SDA] & ~filt_next[SYN_SDA];
    assign stop_seen  = filt_reg[SYN_SCL] & filt_next[SYN_SCL]
                      & ~filt_reg[SYN_SDA] & filt_next[SYN_SDA];
    assign strap_rise = ~filt_reg[SYN_RST] & filt_next[SYN_RST];
    // Toggles are ignored while the link side is held in reset
    assign wr_event   = link_en_reg
                      & (filt_reg[SYN_WR] ^ filt_next[SYN_WR]);
    assign ptr_event  = link_en_reg
                      & (filt_reg[SYN_PTR] ^ filt_next[SYN_PTR]);

    // Strap capture at the release of the device reset pin
    // (RQ2) latch pair choice
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            pair_sel_reg <= PAIR_RST;
        else if (strap_rise)
            pair_sel_reg <= filt_next[SYN_INT];
    end

    // Frame toggle, write strobe and stop pulse
    // (RQ10) stop ends write
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_tgl_reg <= 1'b0;
            reg_wr_reg    <= 1'b0;
            xfer_done_reg <= 1'b0;
            link_en_reg   <= 1'b0;
        end else begin
            frame_tgl_reg <= frame_tgl_reg ^ start_seen;
            reg_wr_reg    <= wr_event;
            xfer_done_reg <= stop_seen;
            link_en_reg   <= filt_reg[SYN_RST];
        end
    end

    // Held words are stable for a whole byte after their toggle moves
    always_ff @(posedge ref_clk) begin
        if (wr_event) begin
            reg_wr_addr_reg <= wr_addr_hold;
            reg_wr_data_reg <= wr_data_hold;
        end
        if (!rst_n)
            reg_rd_addr_reg <= PTR_RST;
        else if (ptr_event)
            reg_rd_addr_reg <= ptr_reg;
        rd_byte_reg <= reg_rd_data;
    end

    assign reg_wr      = reg_wr_reg;
    assign reg_wr_addr = reg_wr_addr_reg;
    assign reg_wr_data = reg_wr_data_reg;
    assign reg_rd_addr = reg_rd_addr_reg;
    assign xfer_done   = xfer_done_reg;
    assign pair_sel    = pair_sel_reg;

    // Reset, frame toggle and pair choice cross into the link domain.
    // The frame toggle is caught on a falling then a rising edge, so a
    // start is known at the second rising edge after it.
    always_ff @(posedge bus.scl) begin
        lrst1_reg <= link_en_reg;
        lrst2_reg <= lrst1_reg;
        fr2_reg   <= fr1_reg;
        ps1_reg   <= pair_sel_reg;
        ps2_reg   <= ps1_reg;
    end

    always_ff @(negedge bus.scl) begin
        fr1_reg <= frame_tgl_reg;
    end

    // Byte framing decode
    // (RQ6) nine clock framing
    assign byte_in   = {sh_reg[6:0], bus.sda};
    assign new_frame = fr2_reg ^ seen_reg;
    assign byte_done = (cnt_reg == BIT_LAST) & ~new_frame;
    assign ack_slot  = (cnt_reg == BIT_ACK) & ~new_frame;
    assign cnt_next  = new_frame ? BIT_NEW :
                       (cnt_reg == BIT_ACK) ? BIT_FIRST : cnt_reg + 4'h1;

    // (RQ1) pair compare
    assign own_wr  = ps2_reg ? PAIR_B_WR : PAIR_A_WR;
    assign own_rd  = ps2_reg ? PAIR_B_RD : PAIR_A_RD;
    assign hit_wr  = (byte_in == own_wr);
    assign hit_rd  = (byte_in == own_rd);
    assign hit_any = hit_wr | hit_rd;

    // (RQ13) host ack check
    assign host_ack  = ack_slot & (phase_reg == PH_RDATA)
                     & ~ack_go_reg & ~bus.sda;
    assign host_nack = ack_slot & (phase_reg == PH_RDATA)
                     & ~ack_go_reg & bus.sda;

    // Ack is owed for our address and every byte written to us
    // (RQ4) ack decision
    assign ack_go_next = byte_done ? ((phase_reg == PH_ADDR) ? hit_any :
                                      (phase_reg != PH_IDLE) &&
                                      (phase_reg != PH_RDATA)) :
                         ack_slot ? 1'b0 : ack_go_reg;

    // Byte-level phase sequence
    always_comb begin
        phase_next = phase_reg;
        if (new_frame) begin
            phase_next = PH_ADDR;
        end else if (byte_done) begin
            case (phase_reg)
                // (RQ5) mismatch goes idle
                PH_ADDR:  phase_next = hit_wr ? PH_PTRH :
                                       hit_rd ? PH_RDATA : PH_IDLE;
                // (RQ8) pointer then data
                PH_PTRH:  phase_next = PH_PTRL;
                PH_PTRL:  phase_next = PH_WDATA;
                PH_WDATA: phase_next = PH_WDATA;
                PH_RDATA: phase_next = PH_RDATA;
                default:  phase_next = PH_IDLE;
            endcase
        end else if (host_nack) begin
            // (RQ14) nack ends read
            phase_next = PH_IDLE;
        end
    end

    // Sampling on the rising edge, while the data line is steady
    always_ff @(posedge bus.scl) begin
        sh_reg <= byte_in;
        if (!lrst2_reg) begin
            cnt_reg    <= BIT_FIRST;
            phase_reg  <= PH_IDLE;
            ack_go_reg <= 1'b0;
            seen_reg   <= fr2_reg;
        end else begin
            cnt_reg    <= cnt_next;
            phase_reg  <= phase_next;
            ack_go_reg <= ack_go_next;
            seen_reg   <= fr2_reg;
        end
    end

    // Pointer load, post-increment and write hand-off
    always_ff @(posedge bus.scl) begin
        if (!lrst2_reg) begin
            ptr_reg     <= PTR_RST;
            ptr_tgl_reg <= 1'b0;
            wr_tgl_reg  <= 1'b0;
        end else if (byte_done && phase_reg == PH_PTRH) begin
            ptr_reg[15:8] <= byte_in;
        end else if (byte_done && phase_reg == PH_PTRL) begin
            // (RQ11) pointer loaded
            ptr_reg[7:0] <= byte_in;
            ptr_tgl_reg  <= ~ptr_tgl_reg;
        end else if (byte_done && phase_reg == PH_WDATA) begin
            // (RQ9) advance after write
            wr_addr_hold <= ptr_reg;
            wr_data_hold <= byte_in;
            wr_tgl_reg   <= ~wr_tgl_reg;
            ptr_reg      <= ptr_reg + 16'h0001;
            ptr_tgl_reg  <= ~ptr_tgl_reg;
        end else if (host_ack) begin
            // (RQ16) advance after send
            ptr_reg     <= ptr_reg + 16'h0001;
            ptr_tgl_reg <= ~ptr_tgl_reg;
        end
    end

    // Read bytes leave MSB first; the fetched byte has settled for
    // almost half a bit time before the first falling edge needs it
    // (RQ12) send from pointer
    assign drive_bit = (cnt_reg == BIT_FIRST) ? rd_byte_reg[7] : tx_reg[7];
    assign tx_next   = (cnt_reg == BIT_FIRST) ? {rd_byte_reg[6:0], 1'b0}
                                              : {tx_reg[6:0], 1'b0};
    assign oe_n_next = !lrst2_reg ? 1'b1 :
                       (cnt_reg == BIT_ACK) ? ~ack_go_reg :
                       (phase_reg == PH_RDATA) ? drive_bit : 1'b1;

    // Data line changes only on the falling edge
    // (RQ7) drive while low
    always_ff @(negedge bus.scl) begin
        tx_reg       <= tx_next;
        // Release level from the reset side covers the first link edges
        sda_oe_n_reg <= oe_n_next | ~link_en_reg;
        sda_o_reg    <= 1'b0;
    end

    assign bus.sda_dev_oe_n = sda_oe_n_reg;
    assign bus.sda_dev_o    = sda_o_reg;

endmodule : touch_i2c_target

// ### core/touch_i2c_host.sv
`timescale 1ns/100ps
module touch_i2c_host
    import touch_i2c_pkg::*;
(
    // System clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Link pins
    touch_i2c_if.host        bus,
    // Strap choice: low picks the first pair
    input  wire logic        pair_sel,
    // Command
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic [15:0] cmd_ptr,
    input  wire logic [7:0]  cmd_len,
    // Write data, taken one byte per pulse
    input  wire logic [7:0]  wr_data,
    output logic             wr_take,
    // Read data and status
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             nack_err
);

    host_state_t  st_reg;
    logic [15:0]  div_reg, strap_reg, ptr_reg;
    logic [1:0]   q_reg;
    logic [3:0]   bit_reg;
    logic [7:0]   len_reg, sh_reg;
    logic [1:0]   idx_reg;
    logic         rd_cmd_reg, rd_ph_reg;
    logic         scl_reg, sda_oe_n_reg, rst_pin_reg, int_reg, int_oe_n_reg;
    logic         cmd_ready_reg, wr_take_reg, rd_valid_reg, nack_reg;
    logic [2:0]   sda_s_reg;
    logic         sda_f_reg, tick, step_end, ack_in, last_rx;
    logic [7:0]   addr_wr, addr_rd;

    // Data line through three flops, change once two and three agree
    always_ff @(posedge ref_clk) begin
        sda_s_reg <= {sda_s_reg[1:0], bus.sda};
        if (!rst_n)
            sda_f_reg <= 1'b1;
        else if (sda_s_reg[1] == sda_s_reg[2])
            sda_f_reg <= sda_s_reg[2];
    end

    // Quarter-bit pacing from the system clock
    // (RQ15) rate just under limit
    assign tick     = (div_reg == 16'h0000);
    assign step_end = tick & (q_reg == 2'h3);
    assign ack_in   = ~sda_f_reg;
    assign last_rx  = (len_reg == 8'h01);
    assign addr_wr  = pair_sel ? PAIR_B_WR : PAIR_A_WR;
    assign addr_rd  = pair_sel ? PAIR_B_RD : PAIR_A_RD;

    always_ff @(posedge ref_clk) begin
        if (!rst_n || tick)
            div_reg <= 16'(QUARTER_CYC - 1);
        else
            div_reg <= div_reg - 16'h0001;
    end

    // Sequencer; clock low in quarters 0-1, high in 2-3
    always_ff @(posedge ref_clk) begin
        wr_take_reg  <= 1'b0;
        rd_valid_reg <= 1'b0;
        nack_reg     <= 1'b0;
        if (!rst_n) begin
            st_reg        <= HS_STRAP;
            q_reg         <= 2'h0;
            strap_reg     <= 16'h0000;
            scl_reg       <= 1'b1;
            sda_oe_n_reg  <= 1'b1;
            rst_pin_reg   <= 1'b0;
            int_reg       <= 1'b0;
            int_oe_n_reg  <= 1'b0;
            cmd_ready_reg <= 1'b0;
        end else begin
            if (tick)
                q_reg <= q_reg + 2'h1;
            // High only in quarters 2-3, so data moves with the clock low
            if (tick && st_reg != HS_IDLE)
                scl_reg <= (q_reg == 2'h1) || (q_reg == 2'h2);
            case (st_reg)
                HS_STRAP: begin
                    // (RQ2) strap pins
                    int_reg   <= pair_sel;
                    strap_reg <= strap_reg + 16'h0001;
                    if (strap_reg == 16'(STRAP_RST_CYC))
                        rst_pin_reg <= 1'b1;
                    if (strap_reg >= 16'(STRAP_END_CYC) && step_end) begin
                        int_oe_n_reg  <= 1'b1;
                        st_reg        <= HS_IDLE;
                        cmd_ready_reg <= 1'b1;
                    end
                end
                HS_IDLE: begin
                    // (RQ3) host starts
                    if (cmd_valid && step_end) begin
                        cmd_ready_reg <= 1'b0;
                        rd_cmd_reg    <= cmd_read;
                        ptr_reg       <= cmd_ptr;
                        len_reg       <= cmd_len;
                        rd_ph_reg     <= 1'b0;
                        st_reg        <= HS_START;
                    end
                end
                HS_START: begin
                    // (RQ12) repeated start
                    // Data falls in quarter 3 while the clock is high
                    if (tick && q_reg == 2'h2)
                        sda_oe_n_reg <= 1'b0;
                    if (step_end) begin
                        sda_oe_n_reg <= rd_ph_reg ? addr_rd[7]
                                                  : addr_wr[7];
                        sh_reg  <= rd_ph_reg ? addr_rd : addr_wr;
                        idx_reg <= 2'h0;
                        bit_reg <= BIT_FIRST;
                        st_reg  <= HS_TX;
                    end
                end
                HS_TX: begin
                    // (RQ6) eight bits then ack
                    if (tick && q_reg == 2'h3)
                        sda_oe_n_reg <= (bit_reg >= BIT_LAST) ? 1'b1
                                                              : sh_reg[6];
                    if (step_end) begin
                        sh_reg  <= {sh_reg[6:0], 1'b0};
                        bit_reg <= (bit_reg == BIT_ACK) ? BIT_FIRST
                                                        : bit_reg + 4'h1;
                    end
                    if (step_end && bit_reg == BIT_ACK) begin
                        idx_reg <= (idx_reg == 2'h3) ? idx_reg
                                                     : idx_reg + 2'h1;
                        if (!ack_in) begin
                            nack_reg <= 1'b1;
                            st_reg   <= HS_STOP;
                        end else if (rd_ph_reg) begin
                            st_reg <= HS_RX;
                        end else if (idx_reg == 2'h0) begin
                            // (RQ8) pointer bytes
                            sh_reg       <= ptr_reg[15:8];
                            sda_oe_n_reg <= ptr_reg[15];
                        end else if (idx_reg == 2'h1) begin
                            sh_reg       <= ptr_reg[7:0];
                            sda_oe_n_reg <= ptr_reg[7];
                        end else if (idx_reg == 2'h2 && rd_cmd_reg) begin
                            // (RQ11) pointer then restart
                            rd_ph_reg <= 1'b1;
                            st_reg    <= HS_START;
                        end else if (len_reg == 8'h00) begin
                            // (RQ10) stop after last
                            st_reg <= HS_STOP;
                        end else begin
                            sh_reg       <= wr_data;
                            sda_oe_n_reg <= wr_data[7];
                            wr_take_reg  <= 1'b1;
                            len_reg      <= len_reg - 8'h01;
                        end
                    end
                end
                HS_RX: begin
                    // (RQ13) ack all but last
                    if (tick && q_reg == 2'h3)
                        sda_oe_n_reg <= (bit_reg == BIT_LAST) ? last_rx
                                                              : 1'b1;
                    if (step_end && bit_reg != BIT_ACK) begin
                        sh_reg  <= {sh_reg[6:0], sda_f_reg};
                        bit_reg <= bit_reg + 4'h1;
                    end
                    if (step_end && bit_reg == BIT_LAST)
                        rd_valid_reg <= 1'b1;
                    if (step_end && bit_reg == BIT_ACK) begin
                        bit_reg <= BIT_FIRST;
                        len_reg <= len_reg - 8'h01;
                        // (RQ14) nack then stop
                        st_reg  <= last_rx ? HS_STOP : HS_RX;
                    end
                end
                HS_STOP: begin
                    // Low while the clock is low, released while high
                    if (tick && q_reg == 2'h0)
                        sda_oe_n_reg <= 1'b0;
                    else if (tick && q_reg == 2'h2)
                        sda_oe_n_reg <= 1'b1;
                    if (step_end) begin
                        st_reg        <= HS_IDLE;
                        cmd_ready_reg <= 1'b1;
                    end
                end
                default: st_reg <= HS_IDLE;
            endcase
        end
    end

    assign bus.scl           = scl_reg;
    assign bus.sda_host_o    = 1'b0;
    assign bus.sda_host_oe_n = sda_oe_n_reg;
    assign bus.dev_rst_n     = rst_pin_reg;
    assign bus.int_host_o    = int_reg;
    assign bus.int_host_oe_n = int_oe_n_reg;
    assign cmd_ready         = cmd_ready_reg;
    assign wr_take           = wr_take_reg;
    assign rd_data           = sh_reg;
    assign rd_valid          = rd_valid_reg;
    assign nack_err          = nack_reg;

endmodule : touch_i2c_host

// ### tb/touch_i2c_checker.sv
`timescale 1ns/100ps
module touch_i2c_checker
    import touch_i2c_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Link wires
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_dev_oe_n,
    input wire logic dev_rst_n,
    input wire logic int_pin
);
    logic       scl_q, sda_q, rd_q, quiet, strap;
    logic [3:0] cnt;
    logic [1:0] bidx;
    logic [7:0] sh;
    // Pin events, seen one ref cycle late
    wire rise  = scl & ~scl_q;
    wire start = scl & scl_q & sda_q & ~sda;
    wire stop  = scl & scl_q & ~sda_q & sda;
    wire ack   = rise & (cnt == 4'h8);
    // Bit position since start; rd_q resets high so strap clocks are masked
    always_ff @(posedge ref_clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (!dev_rst_n) strap <= int_pin;
        if (rise) sh <= {sh[6:0], sda};
        if (!rst_n) rd_q <= 1'b1;
        else if (rise && cnt == 4'h7 && bidx == 2'h0) rd_q <= sda;
        if (!rst_n || start) cnt <= 4'h0;
        else if (rise) cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
        if (!rst_n) bidx <= 2'h3;
        else if (start) bidx <= 2'h0;
        else if (ack && bidx != 2'h3) bidx <= bidx + 2'h1;
        quiet <= rst_n & ~start
               & (quiet | stop | (ack & rd_q & (bidx != 2'h0) & sda));
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rst_fall;
        !dev_rst_n && $fell(scl);
    endsequence
    a_rst_quiet: assert property (s_rst_fall |=> sda_dev_oe_n)
        else $error("target drives data in reset");
    a_change_low: assert property ($changed(sda_dev_oe_n) |-> !scl)
        else $error("target data moved with clock high");
    a_addr_pair: assert property (ack && bidx == 2'h0 |-> sh[7:1] ==
        (strap ? PAIR_B_WR[7:1] : PAIR_A_WR[7:1])) else $error("bad pair");
    a_addr_ack: assert property (ack && bidx == 2'h0 |-> !sda)
        else $error("address not acked");
    a_wr_ack: assert property (ack && !rd_q && !quiet |-> !sda)
        else $error("write byte not acked");
    a_addr_silent: assert property (rise && !cnt[3] && bidx == 2'h0
        |-> sda_dev_oe_n) else $error("target drove address bit");
    a_rd_release: assert property (ack && rd_q && bidx != 2'h0
        |-> sda_dev_oe_n) else $error("target held host ack slot");
    a_end_quiet: assert property (quiet |-> sda_dev_oe_n)
        else $error("target drives after end");
endmodule : touch_i2c_checker

// ### tb/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    n_errors++; $display("wrong value %s exp %h got %h", nm, ex, got); end end
module tb_top;
    logic        ref_clk, pair_out, cmd_ready, wr_take, rd_valid, nack_err;
    logic        rst_n = 1'b0, pair_sel = 1'b0, cmd_valid = 1'b0;
    logic        cmd_read = 1'b0, reg_wr, xfer_done;
    int          ndone = 0;
    logic [15:0] cmd_ptr = 16'h0000, reg_wr_addr, reg_rd_addr;
    logic [7:0]  cmd_len = 8'h00, reg_wr_data, rd_data;
    logic [7:0]  mem [0:65535];
    logic [7:0]  wbuf [0:3] = '{default: 8'h00};
    logic [7:0]  rbuf [0:3];
    int          n_errors = 0, n_checks = 0, widx = 0, ridx = 0, nacks = 0, i;
    wire  [7:0]  wr_data = wbuf[widx[1:0]];
    touch_i2c_if bus_if ();
    touch_i2c_host touch_i2c_host_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus(bus_if.host), .pair_sel(pair_sel), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr),
        .cmd_len(cmd_len), .wr_data(wr_data), .wr_take(wr_take),
        .rd_data(rd_data), .rd_valid(rd_valid), .nack_err(nack_err));
    touch_i2c_target touch_i2c_target_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .bus(bus_if.target), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data), .reg_rd_addr(reg_rd_addr),
        .reg_rd_data(mem[reg_rd_addr]), .xfer_done(xfer_done),
        .pair_sel(pair_out));
    touch_i2c_checker touch_i2c_checker_i (.ref_clk(ref_clk), .rst_n(rst_n),
        .scl(bus_if.scl), .sda(bus_if.sda), .sda_dev_oe_n(bus_if.sda_dev_oe_n),
        .dev_rst_n(bus_if.dev_rst_n), .int_pin(bus_if.int_pin));
    // Register space behind the target and the host's byte streams
    always @(posedge ref_clk) begin
        if (reg_wr) mem[reg_wr_addr] <= reg_wr_data;
        if (wr_take) widx <= widx + 1;
        if (rd_valid) rbuf[ridx[1:0]] <= rd_data;
        if (rd_valid) ridx <= ridx + 1;
        if (nack_err) nacks <= nacks + 1;
        if (xfer_done) ndone <= ndone + 1;
    end
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Watchdog, well past the longest expected run
    initial begin
        #950000;
        n_errors++;
        end_of_test;
    end
    task automatic end_of_test;
        if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    // Sampled on the falling edge so host updates have landed
    task automatic wait_ready(input logic v);
        int k;
        for (k = 0; k < 40000 && cmd_ready !== v; k++) @(negedge ref_clk);
        if (cmd_ready !== v) n_errors++;
    endtask : wait_ready
    task automatic boot(input logic p);
        rst_n <= 1'b0;
        pair_sel <= p;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        wait_ready(1'b1);
        `CHK("pair", p, pair_out)
    endtask : boot
    // One host command, held until the host takes it
    task automatic xfer(input logic rd, input logic [15:0] p, input int n);
        wait_ready(1'b1);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_ptr <= p;
        cmd_len <= n[7:0];
        widx <= 0;
        ridx <= 0;
        wait_ready(1'b0);
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        wait_ready(1'b1);
    endtask : xfer
    initial begin
        boot(1'b0);
        wbuf = '{8'ha5, 8'h3c, 8'h0f, 8'h00};
        // Three bytes across a low-byte carry of the pointer
        xfer(1'b0, 16'h12fe, 3);
        for (i = 0; i < 3; i++) `CHK("mem", wbuf[i], mem[16'h12fe + i])
        xfer(1'b1, 16'h12fe, 3);
        for (i = 0; i < 3; i++) `CHK("rd", wbuf[i], rbuf[i])
        xfer(1'b1, 16'h1300, 1);
        `CHK("rd1", 8'h0f, rbuf[0])
        `CHK("rdn", 1, ridx)
        `CHK("stops", 3, ndone)
        boot(1'b1);
        wbuf[0] = 8'h81;
        xfer(1'b0, 16'h0040, 1);
        `CHK("memb", 8'h81, mem[16'h0040])
        xfer(1'b1, 16'h0040, 1);
        `CHK("rdb", 8'h81, rbuf[0])
        `CHK("nack", 0, nacks)
        end_of_test;
    end
endmodule : tb_top
